// ==== rtl/esie_defines.svh ====
// constants for the extended stack instruction executor
//
// Contract
// - pointer add puts a 6-bit literal onto pointer 0..2, one cycle, no flags
// - selector 11 on pointer add adds to frame pointer then returns from stack top
// - add/subtract with return take two cycles, second one idle while fetching
// - accumulator call pushes current program counter plus two
// - accumulator call loads accumulator into program counter low byte
// - accumulator call loads high and upper latches into program counter
// - accumulator call takes two cycles, second one idle
// - accumulator call saves no shadow copies of accumulator, status or bank
// - indexed-to-absolute move: frame pointer plus 7-bit offset to 12-bit address
// - indexed-to-indexed move: both addresses frame pointer plus 7-bit offsets
// - source on an indirect register moves the value zero
// - indexed destination on an indirect register makes the move do nothing
// - literal push writes literal at frame pointer then decrements it, one cycle
// - pointer subtract takes a 6-bit literal from pointer 0..2, one cycle, no flags
// - selector 11 on pointer subtract uses frame pointer then returns
// - extended first words decode only while the extended-set enable bit is set; a move's second word is taken regardless
`ifndef ESIE_DEFINES_SVH
`define ESIE_DEFINES_SVH

`define ESIE_ADDR_W 12
`define ESIE_PC_W 21
`define ESIE_Q_PER_CYCLE 2'h3

// opcode high bytes and call word, second-word prefix, frame selector and index, pc step
`define ESIE_OP_PTR_ADD 8'he8
`define ESIE_OP_PTR_SUB 8'he9
`define ESIE_OP_LIT_PUSH 8'hea
`define ESIE_OP_IDX_MOVE 8'heb
`define ESIE_OP_ACC_CALL 16'h0014
`define ESIE_SECOND_PREFIX 4'hf
`define ESIE_SEL_FRAME 2'h3
`define ESIE_FRAME_IDX 2'h2
`define ESIE_PC_STEP 21'h000002

// indirect register blocks: five addresses ending at each base
`define ESIE_INDIR_BASE0 12'hfef
`define ESIE_INDIR_BASE1 12'hfe7
`define ESIE_INDIR_BASE2 12'hfdf
`define ESIE_INDIR_SPAN 12'h004

`define ESIE_PTR_RESET 12'h000

`endif

// ==== rtl/esie_exec.sv ====
// decode and execute logic for the extended stack instructions
`timescale 1ns/1ns
`default_nettype none
`include "esie_defines.svh"

module esie_exec
#(
	parameter int PC_W = `ESIE_PC_W
)
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic extSetEnable,
	input wire logic instrValid,
	input wire logic [15:0] instrWord,
	input wire esie_pkg::esie_pc_t pcNow,
	input wire logic [7:0] accum,
	input wire logic [7:0] pcHighLatch,
	input wire logic [7:0] pcUpperLatch,
	input wire esie_pkg::esie_pc_t stackTop,
	input wire logic [7:0] memRdData,
	output logic cycleEn,
	output logic extHit,
	output logic busy,
	output logic pcLoad,
	output esie_pkg::esie_pc_t pcLoadAddr,
	output logic stackPush,
	output esie_pkg::esie_pc_t stackPushAddr,
	output logic stackPop,
	output esie_pkg::esie_addr_t memAddr,
	output logic memRd,
	output logic memWr,
	output logic [7:0] memWrData,
	output esie_pkg::esie_addr_t filePtr0,
	output esie_pkg::esie_addr_t filePtr1,
	output esie_pkg::esie_addr_t filePtr2
);
	import esie_pkg::*;

	// ************************************************************
	// elaboration checks
	// ************************************************************
	// the program counter arithmetic and the package pc type are fixed at 21 bits
	generate
		if (PC_W != `ESIE_PC_W)
		begin : gPcWidthCheck
			$error("esie_exec: PC_W must equal the program counter width");
		end
	endgenerate

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic isIndirect(input esie_addr_t a);
		logic hit;
		hit = 1'b0;
		if (a <= `ESIE_INDIR_BASE0 && a >= (`ESIE_INDIR_BASE0 - `ESIE_INDIR_SPAN))
			hit = 1'b1;
		if (a <= `ESIE_INDIR_BASE1 && a >= (`ESIE_INDIR_BASE1 - `ESIE_INDIR_SPAN))
			hit = 1'b1;
		if (a <= `ESIE_INDIR_BASE2 && a >= (`ESIE_INDIR_BASE2 - `ESIE_INDIR_SPAN))
			hit = 1'b1;
		return hit;
	endfunction : isIndirect

	// ************************************************************
	// quarter-cycle divider
	// ************************************************************
	logic [1:0] qCnt_r;
	logic [1:0] qCnt_nxt;

	always_comb
	begin
		qCnt_nxt = qCnt_r + 2'h1;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			qCnt_r <= 2'h0;
		else
			qCnt_r <= qCnt_nxt;
	end

	// one pulse per instruction cycle, at the last quarter
	assign cycleEn = (qCnt_r == `ESIE_Q_PER_CYCLE);

	// ************************************************************
	// pointer adder
	// ************************************************************
	esie_ptr_if ptrBus ();

	esie_ptr_alu uAlu
	(
		.port(ptrBus.alu)
	);

	// ************************************************************
	// decode
	// ************************************************************
	logic [7:0] opHi;
	logic [1:0] selField;
	logic [5:0] litShort;
	logic isPtrAdd;
	logic isPtrSub;
	logic isLitPush;
	logic isIdxMove;
	logic isAccCall;
	logic isSecondWord;

	always_comb
	begin
		opHi = instrWord[15:8];
		selField = instrWord[7:6];
		litShort = instrWord[5:0];
		isPtrAdd = (opHi == `ESIE_OP_PTR_ADD);
		isPtrSub = (opHi == `ESIE_OP_PTR_SUB);
		isLitPush = (opHi == `ESIE_OP_LIT_PUSH);
		isIdxMove = (opHi == `ESIE_OP_IDX_MOVE);
		isAccCall = (instrWord == `ESIE_OP_ACC_CALL);
		isSecondWord = (instrWord[15:12] == `ESIE_SECOND_PREFIX);
	end

	// ************************************************************
	// execution state
	// ************************************************************
	esie_state_t state_r;
	esie_state_t state_nxt;
	esie_addr_t filePtr_r [3];
	esie_addr_t filePtr_nxt [3];
	esie_addr_t srcAddr_r;
	esie_addr_t srcAddr_nxt;
	logic moveIndexed_r;
	logic moveIndexed_nxt;
	logic pcLoad_r;
	logic pcLoad_nxt;
	esie_pc_t pcLoadAddr_r;
	esie_pc_t pcLoadAddr_nxt;
	logic stackPush_r;
	logic stackPush_nxt;
	esie_pc_t stackPushAddr_r;
	esie_pc_t stackPushAddr_nxt;
	logic stackPop_r;
	logic stackPop_nxt;
	esie_addr_t memAddr_r;
	esie_addr_t memAddr_nxt;
	logic memRd_r;
	logic memRd_nxt;
	logic memWr_r;
	logic memWr_nxt;
	logic [7:0] memWrData_r;
	logic [7:0] memWrData_nxt;
	logic [1:0] ptrIdx;
	logic [7:0] movedByte;

	always_comb
	begin
		state_nxt = state_r;
		filePtr_nxt = filePtr_r;
		srcAddr_nxt = srcAddr_r;
		moveIndexed_nxt = moveIndexed_r;
		pcLoad_nxt = 1'b0;
		pcLoadAddr_nxt = pcLoadAddr_r;
		stackPush_nxt = 1'b0;
		stackPushAddr_nxt = stackPushAddr_r;
		stackPop_nxt = 1'b0;
		memAddr_nxt = memAddr_r;
		memRd_nxt = 1'b0;
		memWr_nxt = 1'b0;
		memWrData_nxt = memWrData_r;
		ptrBus.base = filePtr_r[`ESIE_FRAME_IDX];
		ptrBus.operand = 12'h000;
		ptrBus.subtract = 1'b0;
		ptrIdx = (selField == `ESIE_SEL_FRAME) ? `ESIE_FRAME_IDX : selField;
		// read data is zero when the source sits on an indirect register
		movedByte = isIndirect(srcAddr_r) ? 8'h00 : memRdData;
		extHit = 1'b0;

		case (state_r)
			ESIE_ST_IDLE:
			begin
				// nothing here is decoded while the extension is off
				if (cycleEn && instrValid && extSetEnable)
				begin
					if (isPtrAdd || isPtrSub)
					begin
						extHit = 1'b1;
						ptrBus.base = filePtr_r[ptrIdx];
						ptrBus.operand = {6'h00, litShort};
						ptrBus.subtract = isPtrSub;
						filePtr_nxt[ptrIdx] = ptrBus.result;
						if (selField == `ESIE_SEL_FRAME)
						begin
							pcLoad_nxt = 1'b1;
							pcLoadAddr_nxt = stackTop;
							stackPop_nxt = 1'b1;
							state_nxt = ESIE_ST_FLUSH;
						end
					end
					else if (isLitPush)
					begin
						extHit = 1'b1;
						memAddr_nxt = filePtr_r[`ESIE_FRAME_IDX];
						memWr_nxt = 1'b1;
						memWrData_nxt = instrWord[7:0];
						ptrBus.operand = 12'h001;
						ptrBus.subtract = 1'b1;
						filePtr_nxt[`ESIE_FRAME_IDX] = ptrBus.result;
					end
					else if (isIdxMove)
					begin
						extHit = 1'b1;
						ptrBus.operand = {5'h00, instrWord[6:0]};
						srcAddr_nxt = ptrBus.result;
						memAddr_nxt = ptrBus.result;
						memRd_nxt = 1'b1;
						moveIndexed_nxt = instrWord[7];
						state_nxt = ESIE_ST_MOVE2;
					end
					else if (isAccCall)
					begin
						// no shadow save or restore happens on this call
						extHit = 1'b1;
						stackPush_nxt = 1'b1;
						stackPushAddr_nxt = pcNow + `ESIE_PC_STEP;
						pcLoad_nxt = 1'b1;
						pcLoadAddr_nxt = {pcUpperLatch[4:0], pcHighLatch, accum};
						state_nxt = ESIE_ST_FLUSH;
					end
				end
			end
			ESIE_ST_MOVE2:
			begin
				// waits for the second word; a stray first-word opcode is not expected
				if (cycleEn && instrValid && isSecondWord)
				begin
					extHit = 1'b1;
					memWrData_nxt = movedByte;
					state_nxt = ESIE_ST_IDLE;
					if (moveIndexed_r)
					begin
						ptrBus.operand = {5'h00, instrWord[6:0]};
						memAddr_nxt = ptrBus.result;
						// an indirect destination turns the whole move into a no-op
						memWr_nxt = !isIndirect(ptrBus.result);
					end
					else
					begin
						memAddr_nxt = instrWord[11:0];
						memWr_nxt = 1'b1;
					end
				end
			end
			ESIE_ST_FLUSH:
			begin
				// idle cycle while the new target is fetched
				if (cycleEn)
					state_nxt = ESIE_ST_IDLE;
			end
			default:
			begin
				state_nxt = ESIE_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= ESIE_ST_IDLE;
			filePtr_r[0] <= `ESIE_PTR_RESET;
			filePtr_r[1] <= `ESIE_PTR_RESET;
			filePtr_r[2] <= `ESIE_PTR_RESET;
			srcAddr_r <= 12'h000;
			moveIndexed_r <= 1'b0;
			pcLoad_r <= 1'b0;
			pcLoadAddr_r <= 21'h000000;
			stackPush_r <= 1'b0;
			stackPushAddr_r <= 21'h000000;
			stackPop_r <= 1'b0;
			memAddr_r <= 12'h000;
			memRd_r <= 1'b0;
			memWr_r <= 1'b0;
			memWrData_r <= 8'h00;
		end
		else
		begin
			state_r <= state_nxt;
			filePtr_r <= filePtr_nxt;
			srcAddr_r <= srcAddr_nxt;
			moveIndexed_r <= moveIndexed_nxt;
			pcLoad_r <= pcLoad_nxt;
			pcLoadAddr_r <= pcLoadAddr_nxt;
			stackPush_r <= stackPush_nxt;
			stackPushAddr_r <= stackPushAddr_nxt;
			stackPop_r <= stackPop_nxt;
			memAddr_r <= memAddr_nxt;
			memRd_r <= memRd_nxt;
			memWr_r <= memWr_nxt;
			memWrData_r <= memWrData_nxt;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign busy = (state_r != ESIE_ST_IDLE);
	assign pcLoad = pcLoad_r;
	assign pcLoadAddr = pcLoadAddr_r;
	assign stackPush = stackPush_r;
	assign stackPushAddr = stackPushAddr_r;
	assign stackPop = stackPop_r;
	assign memAddr = memAddr_r;
	assign memRd = memRd_r;
	assign memWr = memWr_r;
	assign memWrData = memWrData_r;
	assign filePtr0 = filePtr_r[0];
	assign filePtr1 = filePtr_r[1];
	assign filePtr2 = filePtr_r[2];

endmodule : esie_exec

`default_nettype wire

// ==== rtl/esie_pkg.sv ====
// types shared by the extended stack instruction executor
package esie_pkg;

	typedef logic [11:0] esie_addr_t;
	typedef logic [20:0] esie_pc_t;

	typedef enum logic [1:0]
	{
		ESIE_ST_IDLE = 2'h0,
		ESIE_ST_MOVE2 = 2'h1,
		ESIE_ST_FLUSH = 2'h2
	} esie_state_t;

endpackage : esie_pkg

// ==== rtl/esie_ptr_alu.sv ====
// full-width pointer adder and subtractor
`timescale 1ns/1ns
`default_nettype none

module esie_ptr_alu
(
	esie_ptr_if.alu port
);
	import esie_pkg::*;

	// carry and borrow ripple through all twelve bits, never byte-wrapped
	always_comb
	begin
		if (port.subtract)
			port.result = port.base - port.operand;
		else
			port.result = port.base + port.operand;
	end

endmodule : esie_ptr_alu

`default_nettype wire

// ==== rtl/esie_ptr_if.sv ====
// pointer arithmetic request and result between executor and adder
`timescale 1ns/1ns
`default_nettype none

interface esie_ptr_if;
	logic [11:0] base;
	logic [11:0] operand;
	logic subtract;
	logic [11:0] result;

	modport user (output base, output operand, output subtract, input result);
	modport alu (input base, input operand, input subtract, output result);
endinterface : esie_ptr_if

`default_nettype wire

// ==== tb/esie_data_mem.sv ====
// data memory model answering the executor's reads and writes
`timescale 1ns/1ns
`default_nettype none
module esie_data_mem
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic cycleEn,
	input wire esie_pkg::esie_addr_t memAddr,
	input wire logic memRd,
	input wire logic memWr,
	input wire logic [7:0] memWrData,
	output logic [7:0] memRdData
);
	import esie_pkg::*;
	logic [7:0] mem [4096];
	logic [7:0] rdR = 8'h00;
	logic hold;
	initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5a;
	// read data only stands until the next strobe, then shows garbage
	assign memRdData = hold ? rdR : ~rdR;
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			hold <= 1'b0;
		else
		begin
			if (memWr)
				mem[memAddr] <= memWrData;
			if (memRd)
				rdR <= mem[memAddr];
			hold <= memRd || (hold && !cycleEn);
		end
	end
endmodule : esie_data_mem
`default_nettype wire

// ==== tb/esie_exec_sva.sv ====
// concurrent checks on the ports of the extended stack instruction executor
`timescale 1ns/1ns
`default_nettype none
module esie_exec_sva
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic extSetEnable,
	input wire logic [15:0] instrWord,
	input wire esie_pkg::esie_pc_t pcNow,
	input wire logic [7:0] accum,
	input wire logic [7:0] pcHighLatch,
	input wire logic [7:0] pcUpperLatch,
	input wire esie_pkg::esie_pc_t stackTop,
	input wire logic cycleEn,
	input wire logic extHit,
	input wire logic busy,
	input wire logic pcLoad,
	input wire esie_pkg::esie_pc_t pcLoadAddr,
	input wire logic stackPush,
	input wire esie_pkg::esie_pc_t stackPushAddr,
	input wire logic stackPop,
	input wire esie_pkg::esie_addr_t memAddr,
	input wire logic memRd,
	input wire logic memWr,
	input wire logic [7:0] memWrData,
	input wire esie_pkg::esie_addr_t filePtr0,
	input wire esie_pkg::esie_addr_t filePtr1,
	input wire esie_pkg::esie_addr_t filePtr2
);
	import esie_pkg::*;
	// ****************
	// checks
	// ****************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// first word of an instruction, never the second word of a move
	logic w1;
	assign w1 = extHit && !busy;
	chk_cycle_gap: assert property (
		cycleEn |=> !cycleEn [*3] ##1 cycleEn) else $error("cycle strobe spacing wrong");
	chk_disabled_quiet: assert property (
		!extSetEnable |-> !extHit) else $error("extended word taken while disabled");
	chk_ptr_add: assert property (
		w1 && instrWord[15:6] == 10'h3a0 |=> filePtr0 == $past(filePtr0) + 12'($past(instrWord[5:0])))
		else $error("pointer add result wrong");
	chk_ptr_sub: assert property (
		w1 && instrWord[15:6] == 10'h3a5 |=> filePtr1 == $past(filePtr1) - 12'($past(instrWord[5:0])))
		else $error("pointer subtract result wrong");
	chk_ret_pop: assert property (
		w1 && instrWord[15:9] == 7'h74 && instrWord[7:6] == 2'h3
		|=> stackPop && pcLoad && pcLoadAddr == $past(stackTop)) else $error("return not taken");
	chk_call_push: assert property (
		w1 && instrWord == 16'h0014 |=> stackPush && stackPushAddr == $past(pcNow) + 21'h000002
		&& pcLoadAddr == {$past(pcUpperLatch[4:0]), $past(pcHighLatch), $past(accum)})
		else $error("accumulator call wrong");
	chk_flush_slot: assert property (
		pcLoad |-> busy [*3] ##1 (busy && cycleEn) ##1 !busy) else $error("flush cycle wrong");
	chk_push_dec: assert property (
		w1 && instrWord[15:8] == 8'hea |=> memWr && memAddr == $past(filePtr2)
		&& memWrData == $past(instrWord[7:0]) && filePtr2 == $past(filePtr2) - 12'h001)
		else $error("literal push wrong");
	chk_move_read: assert property (
		w1 && instrWord[15:8] == 8'heb |=> memRd && memAddr == $past(filePtr2) + 12'($past(instrWord[6:0])))
		else $error("move source read wrong");
	cover property (pcLoad && stackPop);
	cover property (stackPush);
	cover property (memRd);
endmodule : esie_exec_sva
`default_nettype wire

// ==== tb/test_esie_exec.sv ====
// self-checking bench for the extended stack instruction executor
`timescale 1ns/1ns
`default_nettype none
module test_esie_exec;
	import esie_pkg::*;
	logic mclk, rst_b, extSetEnable, instrValid, cycleEn, extHit, busy, pcLoad, stackPush;
	logic stackPop, memRd, memWr;
	logic [15:0] instrWord;
	logic [7:0] accum, pcHighLatch, pcUpperLatch, memRdData, memWrData;
	esie_pc_t pcNow, stackTop, pcLoadAddr, stackPushAddr;
	esie_addr_t memAddr, filePtr0, filePtr1, filePtr2;
	int miscompares = 0;
	int n_checks = 0;
	int fp [3];
	logic [7:0] mref [int];
	logic hit;
	esie_exec DUT (.*);
	esie_data_mem mem (.*);
	// ****************
	// helpers
	// ****************
	task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	// holds the word until a strobe takes it; flush strobes are skipped
	task automatic issue(input logic [15:0] w, input logic mid);
		@(posedge mclk);
		instrWord <= w;
		instrValid <= 1'b1;
		pcNow <= 21'($urandom);
		accum <= 8'($urandom);
		pcHighLatch <= 8'($urandom);
		pcUpperLatch <= 8'($urandom);
		stackTop <= 21'($urandom);
		do @(negedge mclk); while (!cycleEn || (busy && !mid));
		hit = extHit;
		@(posedge mclk);
		instrValid <= 1'b0;
		@(negedge mclk);
	endtask : issue
	function automatic bit ind(input int a);
		return a inside {[32'hfdb:32'hfdf], [32'hfe3:32'hfe7], [32'hfeb:32'hfef]};
	endfunction : ind
	function automatic logic [7:0] rd(input int a);
		if (ind(a))
			return 8'h00;
		return mref.exists(a) ? mref[a] : 8'(a) ^ 8'h5a;
	endfunction : rd
	task automatic ptr(input int d, input int s, input int k);
		int j;
		j = s > 1 ? 2 : s;
		issue({7'h74, d[0], s[1:0], k[5:0]}, 1'b0);
		fp[j] = (d ? fp[j] - k : fp[j] + k) & 32'hfff;
		chk(hit, 21'h1);
		chk(j == 0 ? filePtr0 : j == 1 ? filePtr1 : filePtr2, 21'(fp[j]));
	endtask : ptr
	task automatic mv(input int x, input int zs, input int dst);
		int src, dest;
		logic [7:0] e;
		logic wr;
		src = (fp[2] + zs) & 32'hfff;
		dest = x ? (fp[2] + (dst & 32'h7f)) & 32'hfff : dst & 32'hfff;
		e = rd(src);
		wr = !(x && ind(dest));
		issue({8'heb, x[0], zs[6:0]}, 1'b0);
		chk({memRd, busy, memAddr}, {2'h3, src[11:0]});
		issue({4'hf, dst[11:0]}, 1'b1);
		if (wr)
		begin
			mref[dest] = e;
			chk({memWr, memAddr, memWrData}, {1'b1, dest[11:0], e});
		end
		else
			chk(memWr, 21'h0);
	endtask : mv
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial
	begin
		#2000000;
		miscompares++;
		finish_test;
	end
	initial
	begin
		int k, a;
		rst_b = 1'b0;
		extSetEnable = 1'b0;
		instrValid = 1'b0;
		instrWord = 16'h0000;
		pcNow = 21'h000000;
		accum = 8'h00;
		pcHighLatch = 8'h00;
		pcUpperLatch = 8'h00;
		stackTop = 21'h000000;
		void'($urandom(32'h6475));
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		@(negedge mclk);
		chk(21'(filePtr0), 21'h0);
		chk(21'(filePtr2), 21'h0);
		issue(16'he845, 1'b0);
		chk({hit, filePtr1}, 21'h0);
		$display("test disabled done");
		@(posedge mclk);
		extSetEnable <= 1'b1;
		// standard opcode with the extension on: nothing may happen
		issue(16'h0015, 1'b0);
		chk({hit, memWr, memRd, pcLoad, stackPush, stackPop}, 21'h0);
		// first two fixed: add on pointer 0, then subtract with borrow on pointer 1
		for (int i = 0; i < 16; i++)
			ptr(i < 2 ? i : $urandom_range(1), i < 2 ? i : $urandom_range(2),
				i ? $urandom_range(63) : 63);
		$display("test pointer done");
		for (int d = 0; d < 2; d++)
		begin
			ptr(d, 3, $urandom_range(63));
			chk({pcLoad, stackPop, busy, stackPush}, 21'he);
			chk(pcLoadAddr, stackTop);
		end
		issue(16'h0014, 1'b0);
		chk({stackPush, pcLoad, busy, stackPop, memWr}, 21'h1c);
		chk(stackPushAddr, pcNow + 21'h000002);
		chk(pcLoadAddr, {pcUpperLatch[4:0], pcHighLatch, accum});
		$display("test return and call done");
		// land the frame pointer just below the indirect block
		while (fp[2] < 32'hf90 || fp[2] > 32'hfd0)
			ptr(1, 2, 63);
		for (int i = 0; i < 4; i++)
		begin
			k = i ? $urandom_range(255) : 255;
			a = fp[2];
			issue({8'hea, k[7:0]}, 1'b0);
			mref[a] = k[7:0];
			fp[2] = (a - 1) & 32'hfff;
			chk({memWr, memAddr, memWrData}, {1'b1, a[11:0], k[7:0]});
			chk(filePtr2, 21'(fp[2]));
		end
		$display("test push done");
		mv(0, $urandom_range(127), $urandom_range(32'heff));
		mv(0, 32'hfdf - fp[2], $urandom_range(32'heff));
		mv(1, 1, $urandom & 32'hf8f);
		mv(1, $urandom_range(127), 32'hf80 | (32'hfeb - fp[2]));
		$display("test move done");
		finish_test;
	end
endmodule : test_esie_exec
bind esie_exec esie_exec_sva chk (.*);
`default_nettype wire
